/* File: sdbpc_pkg.sv */
// package: constants and state types for the bank close controller
`default_nettype none
package sdbpc_pkg;
	localparam int NUM_BANKS = 8;
	localparam int CA_W = 10;
	localparam int CNT_W = 5;
	// command field positions: all-bank and bank on the rising-edge word, auto-close on the falling-edge word
	localparam int ALL_BANK_POS = 4;
	localparam int BANK_LO_POS = 7;
	localparam int AUTO_CLOSE_POS = 0;
	// command codes, low bits of the rising-edge word
	localparam logic [3:0] CMD_PRE = 4'hB;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h1;
	localparam logic [1:0] CMD_ACT = 2'h2;
	// write-close starts this many cycles after the last data
	localparam logic [CNT_W-1:0] WR_CLOSE_GAP = 5'h02;
	// one prefetch group takes two clocks of double-rate data
	localparam logic [CNT_W-1:0] GROUP_CLKS = 5'h02;
	localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
	localparam logic [7:0] BANKS_RESET = 8'h00;
	// half the burst length from the 2-bit burst code 0:4 1:8 2,3:16
	function automatic logic [CNT_W-1:0] half_burst(input logic [1:0] code);
		unique case (code)
			2'h0: half_burst = 5'h02;
			2'h1: half_burst = 5'h04;
			default: half_burst = 5'h08;
		endcase
	endfunction
	typedef struct packed {
		logic open;
		logic armed;
		logic [CNT_W-1:0] cnt;
		logic close_start;
	} sdbpc_bank_t;
endpackage
`default_nettype wire

/* File: sdbpc_bank_if.sv */
// interface: per-bank command and status between decoder and bank unit
`timescale 1ns/100ps
`default_nettype none
interface sdbpc_bank_if;
	logic close_now;
	logic activate;
	logic ap_arm;
	logic [4:0] ap_delay;
	logic open;
	logic close_start;
	modport ctrl (output close_now, activate, ap_arm, ap_delay,
		input open, close_start);
	modport bank (input close_now, activate, ap_arm, ap_delay,
		output open, close_start);
endinterface
`default_nettype wire

/* File: sdbpc_bank.sv */
// module: one bank's open state and auto-close countdown
`timescale 1ns/100ps
`default_nettype none
module sdbpc_bank (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// command side
	sdbpc_bank_if.bank bif
);
	sdbpc_pkg::sdbpc_bank_t st_reg, st_next;

	// next state: explicit close, countdown, activation
	always_comb begin
		st_next = st_reg;
		st_next.close_start = 1'b0;
		if (bif.close_now) begin
			st_next.open = 1'b0;
			st_next.armed = 1'b0;
			st_next.close_start = st_reg.open;
		end else if (bif.ap_arm) begin
			st_next.armed = 1'b1;
			st_next.cnt = bif.ap_delay;
		end else if (st_reg.armed) begin
			if (st_reg.cnt <= 5'h01) begin
				st_next.armed = 1'b0; // countdown done: start closing
				st_next.open = 1'b0;
				st_next.close_start = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt - 5'h01;
			end
		end else if (bif.activate) begin
			st_next.open = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bif.open = st_reg.open;
	assign bif.close_start = st_reg.close_start;
endmodule
`default_nettype wire

/* File: sdbpc_ctrl.sv */
// module: command decoder for bank close, auto-close and array write groups
// Function
// - Precharge is chip select low with CA3..CA0 pattern high-low-high-high.
// - All-bank flag on CA4 at rising edge closes every bank.
// - Flag low: CA9..CA7 select the single bank to close.
// - Array write begins only after a full four-word group is latched.
// - Auto-close flag sampled on CA0 falling edge; low leaves bank open.
// - Auto-close flag high closes the bank at earliest permitted point.
// - Read auto-close starts at max of half burst, half burst-2+RTP clocks.
// - Write auto-close starts two clocks after the write burst completes.
`timescale 1ns/100ps
`default_nettype none
module sdbpc_ctrl (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// command pins, rising and falling edge captures
	input wire logic CS_N,
	input wire logic [9:0] CA_RISE,
	input wire logic [9:0] CA_FALL,
	// configuration
	input wire logic [1:0] BURST_LEN_CODE,
	input wire logic [4:0] WRITE_LATENCY,
	input wire logic [4:0] RTP_CLKS,
	// status
	output logic [7:0] BANK_OPEN,
	output logic [7:0] BANK_CLOSE_START,
	output logic ARRAY_WRITE,
	output logic [2:0] ARRAY_WRITE_BANK
);
	typedef struct packed {
		logic cs1_n;
		logic cs2_n;
		logic [9:0] car1;
		logic [9:0] car2;
		logic [9:0] caf1;
		logic [9:0] caf2;
		logic [7:0] open;
		logic [7:0] close_start;
		logic wr_busy;
		logic [4:0] wr_cnt;
		logic [3:0] wr_groups;
		logic [2:0] wr_bank;
		logic aw;
		logic [2:0] aw_bank;
	} sdbpc_state_t;

	sdbpc_state_t st_reg, st_next;
	sdbpc_bank_if bif [sdbpc_pkg::NUM_BANKS] ();
	logic [7:0] bank_open;
	logic [7:0] bank_close;
	logic is_pre, is_read, is_write, is_act, all_flag, ap_flag;
	logic [2:0] bank_sel;
	logic [4:0] bl2, rd_dly, wr_dly;

	////////////////////////////////////////////////////////////////
	// command decode on the second synchroniser stage
	always_comb begin
		is_pre = !st_reg.cs2_n && (st_reg.car2[3:0] == sdbpc_pkg::CMD_PRE);
		is_read = !st_reg.cs2_n && (st_reg.car2[2:0] == sdbpc_pkg::CMD_READ);
		is_write = !st_reg.cs2_n
			&& (st_reg.car2[2:0] == sdbpc_pkg::CMD_WRITE);
		is_act = !st_reg.cs2_n && (st_reg.car2[1:0] == sdbpc_pkg::CMD_ACT);
		all_flag = st_reg.car2[sdbpc_pkg::ALL_BANK_POS];
		bank_sel = st_reg.car2[sdbpc_pkg::BANK_LO_POS +: 3];
		ap_flag = st_reg.caf2[sdbpc_pkg::AUTO_CLOSE_POS];
		bl2 = sdbpc_pkg::half_burst(BURST_LEN_CODE);
		// read close point: later of half burst and half burst-2+RTP
		rd_dly = (RTP_CLKS > 5'h02) ? 5'(bl2 + RTP_CLKS - 5'h02) : bl2;
		// write close point: two clocks after the last data clock
		wr_dly = 5'(WRITE_LATENCY + bl2 + sdbpc_pkg::WR_CLOSE_GAP);
	end

	////////////////////////////////////////////////////////////////
	// per-bank units and their command fan-out
	genvar g;
	generate
		for (g = 0; g < sdbpc_pkg::NUM_BANKS; g++) begin : gen_bank
			logic hit;
			assign hit = (bank_sel == 3'(g));
			// all-bank overrides the select bits
			assign bif[g].close_now = is_pre && (all_flag || hit);
			assign bif[g].activate = is_act && hit;
			// flag high arms the auto-close, low leaves the bank open
			assign bif[g].ap_arm = (is_read || is_write) && hit && ap_flag;
			assign bif[g].ap_delay = is_read ? rd_dly : wr_dly;
			assign bank_open[g] = bif[g].open;
			assign bank_close[g] = bif[g].close_start;
			sdbpc_bank u_sdbpc_bank (
				.clk(CLK),
				.reset(RESET),
				.bif(bif[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// synchronisers, status capture and array write groups
	always_comb begin
		st_next = st_reg;
		st_next.cs1_n = CS_N;
		st_next.cs2_n = st_reg.cs1_n;
		st_next.car1 = CA_RISE;
		st_next.car2 = st_reg.car1;
		st_next.caf1 = CA_FALL;
		st_next.caf2 = st_reg.caf1;
		st_next.open = bank_open;
		st_next.close_start = bank_close;
		st_next.aw = 1'b0;
		if (is_write) begin
			// first group is whole two clocks after write latency
			st_next.wr_busy = 1'b1;
			st_next.wr_cnt = 5'(WRITE_LATENCY + sdbpc_pkg::GROUP_CLKS);
			st_next.wr_groups = 4'(bl2 >> 1);
			st_next.wr_bank = bank_sel;
		end else if (st_reg.wr_busy) begin
			if (st_reg.wr_cnt <= 5'h01) begin
				st_next.aw = 1'b1; // group latched, commit to array
				st_next.aw_bank = st_reg.wr_bank;
				st_next.wr_cnt = sdbpc_pkg::GROUP_CLKS;
				st_next.wr_groups = st_reg.wr_groups - 4'h1;
				st_next.wr_busy = (st_reg.wr_groups > 4'h1);
			end else begin
				st_next.wr_cnt = st_reg.wr_cnt - 5'h01;
			end
		end
	end

	// state register
	always_ff @(posedge CLK) begin
		if (RESET) begin
			st_reg <= '0;
			st_reg.cs1_n <= 1'b1;
			st_reg.cs2_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign BANK_OPEN = st_reg.open;
	assign BANK_CLOSE_START = st_reg.close_start;
	assign ARRAY_WRITE = st_reg.aw;
	assign ARRAY_WRITE_BANK = st_reg.aw_bank;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	// the pin pattern with the all-bank flag empties the bank map
	a_pre_decode: assert property (
		!CS_N && CA_RISE[3:0] == 4'hB && CA_RISE[4]
		|-> ##3 bank_open == 8'h00)
		else $error("precharge pattern did not close the banks");

	// every bank open at the command shows its close pulse
	a_all_bank_close: assert property (
		is_pre && all_flag |=> ##1 BANK_CLOSE_START == $past(bank_open, 2))
		else $error("all-bank close did not reach every open bank");

	// single close pulses only the selected bank
	a_single_bank: assert property (
		is_pre && !all_flag && bank_open[bank_sel]
		|=> ##1 BANK_CLOSE_START == (8'h01 << $past(bank_sel, 2)))
		else $error("single-bank close hit the wrong banks");

	// a bank that is already closed gives no pulse
	a_closed_quiet: assert property (
		is_pre && !all_flag && !bank_open[bank_sel]
		|=> ##1 !BANK_CLOSE_START[$past(bank_sel, 2)])
		else $error("closed bank pulsed on single close");

	// flag low: the addressed bank stays open after the command
	a_no_ap_open: assert property (
		(is_read || is_write) && !ap_flag && bank_open[bank_sel]
		|=> bank_open[$past(bank_sel)])
		else $error("bank closed without auto-close");

	// flag high: a close pulse follows within the longest countdown
	a_ap_arms: assert property (
		(is_read || is_write) && ap_flag |-> ##[2:32] bank_close != 8'h00)
		else $error("auto-close never started");

	// read-to-close branch: BL8 with three clocks starts five after
	a_rd_ap_time: assert property (
		is_read && ap_flag && bank_sel == 3'h6 && BURST_LEN_CODE == 2'h1
		&& RTP_CLKS == 5'h03 |-> (!bank_close[6])[*6] ##1 bank_close[6])
		else $error("read auto-close not at read-to-close point");

	// half-burst branch: BL16 with one clock starts eight after
	a_rd_ap_half: assert property (
		is_read && ap_flag && bank_sel == 3'h6 && BURST_LEN_CODE == 2'h2
		&& RTP_CLKS == 5'h01
		|-> ##1 (!bank_close[6])[*8] ##1 bank_close[6])
		else $error("read auto-close not at half burst");

	// latency three, BL4: data ends at five, close starts two later
	a_wr_ap_time: assert property (
		is_write && ap_flag && bank_sel == 3'h4 && WRITE_LATENCY == 5'h03
		&& BURST_LEN_CODE == 2'h0
		|-> (!bank_close[4])[*8] ##1 bank_close[4])
		else $error("write auto-close not two clocks after burst");

	// first group commits once its two data clocks are latched
	a_group_write: assert property (
		is_write && WRITE_LATENCY == 5'h03
		|-> (!ARRAY_WRITE)[*6] ##1 ARRAY_WRITE)
		else $error("array write not after first full group");

	// BL16 gives four groups two clocks apart
	a_group_train: assert property (
		is_write && WRITE_LATENCY == 5'h03 && BURST_LEN_CODE == 2'h2
		|-> ##6 ARRAY_WRITE ##1 !ARRAY_WRITE ##1 ARRAY_WRITE ##1 !ARRAY_WRITE
		##1 ARRAY_WRITE ##1 !ARRAY_WRITE ##1 ARRAY_WRITE ##1 !ARRAY_WRITE)
		else $error("array write groups not two clocks apart");

	c_all_close: cover property (is_pre && all_flag);
	c_single_close: cover property (is_pre && !all_flag
		&& bank_open[bank_sel]);
	c_read_ap: cover property (is_read && ap_flag ##[1:20] bank_close != 8'h00);
	c_write_ap: cover property (is_write && ap_flag ##[1:30] ARRAY_WRITE);
endmodule
`default_nettype wire

/* File: sdbpc_host_model.sv */
// partner model: memory controller issuing commands on the pins
`timescale 1ns/100ps
`default_nettype none
module sdbpc_host_model (
	// clock
	input wire logic clk,
	// command pins
	output logic cs_n,
	output logic [9:0] ca_rise,
	output logic [9:0] ca_fall
);
	// deselected and idle from time zero
	initial begin
		cs_n = 1'b1;
		ca_rise = 10'h3FF;
		ca_fall = 10'h3FF;
	end
	// one command for one cycle, then release and idle for the spacing
	task automatic send(input logic [9:0] r, input logic [9:0] f,
		input int gap, input logic sel_n = 1'b0);
		@(posedge clk);
		cs_n <= sel_n;
		ca_rise <= r;
		ca_fall <= f;
		@(posedge clk); // no stop or cut burst
		// released bus shows the inverse so a stale value never decodes
		cs_n <= 1'b1;
		ca_rise <= ~r;
		ca_fall <= ~f;
		// callers pass a gap that keeps every minimum spacing
		repeat (gap) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* File: tb_sdram_bank_precharge_control.sv */
// testbench: bank close, all-bank close and auto-close timing
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb_sdram_bank_precharge_control;
	logic CLK = 1'b0, RESET = 1'b1, CS_N;
	logic [9:0] CA_RISE, CA_FALL;
	logic [1:0] BURST_LEN_CODE = 2'h0;
	logic [4:0] WRITE_LATENCY = 5'h03, RTP_CLKS = 5'h01;
	logic [7:0] BANK_OPEN, BANK_CLOSE_START, v;
	logic ARRAY_WRITE;
	logic [2:0] ARRAY_WRITE_BANK;
	int miscompares = 0, n_checks = 0, at, h, d, nw;
	sdbpc_host_model u_sdbpc_host_model (.clk(CLK), .cs_n(CS_N),
		.ca_rise(CA_RISE), .ca_fall(CA_FALL));
	sdbpc_ctrl u_sdbpc_ctrl (.CLK(CLK), .RESET(RESET), .CS_N(CS_N),
		.CA_RISE(CA_RISE), .CA_FALL(CA_FALL),
		.BURST_LEN_CODE(BURST_LEN_CODE), .WRITE_LATENCY(WRITE_LATENCY),
		.RTP_CLKS(RTP_CLKS), .BANK_OPEN(BANK_OPEN),
		.BANK_CLOSE_START(BANK_CLOSE_START), .ARRAY_WRITE(ARRAY_WRITE),
		.ARRAY_WRITE_BANK(ARRAY_WRITE_BANK));
	// 50 ns clock
	initial begin
		forever #25 CLK = ~CLK;
	end
	////////////////////////////////////////////////////////////////////
	function automatic logic [9:0] pre(input logic ab, input logic [2:0] b);
		return {b, 2'b00, ab, sdbpc_pkg::CMD_PRE};
	endfunction
	// bank on both possible field positions of an activate
	function automatic logic [9:0] act(input logic [2:0] b);
		return {b, b, 2'b00, sdbpc_pkg::CMD_ACT};
	endfunction
	function automatic logic [9:0] rw(input logic [2:0] b, input logic w);
		return {b, 4'h0, w ? sdbpc_pkg::CMD_WRITE : sdbpc_pkg::CMD_READ};
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// edge of the first close pulse counted from the command edge
	task automatic wait_close(input int lim, input logic must);
		at = -1;
		v = 8'h00;
		for (int i = 2; i <= lim && at < 0; i++) begin
			@(posedge CLK);
			#1;
			if (BANK_CLOSE_START !== 8'h00) begin
				at = i;
				v = BANK_CLOSE_START;
			end
		end
		if (at < 0 && must) begin
			miscompares++;
			tally_and_finish;
		end
	endtask
	task automatic cfg(input logic [1:0] c, input logic [4:0] rtp);
		@(posedge CLK);
		BURST_LEN_CODE <= c;
		RTP_CLKS <= rtp;
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_single;
		for (int b = 0; b < 8; b++) u_sdbpc_host_model.send(act(b), 0, 6);
		`CHK(BANK_OPEN, 8'hFF)
		for (int b = 0; b < 8; b++) begin
			u_sdbpc_host_model.send(pre(1'b0, b), 10'h000, 0);
			wait_close(12, 1'b1);
			`CHK(v, 8'h01 << b)
			`CHK(at, 4)
		end
		$display("test single done");
	endtask
	task automatic t_all;
		for (int b = 0; b < 8; b += 3) u_sdbpc_host_model.send(act(b), 0, 6);
		u_sdbpc_host_model.send(pre(1'b1, 3'h2) & 10'h3F7, 10'h000, 0);
		wait_close(10, 1'b0);
		`CHK(at, -1)
		u_sdbpc_host_model.send(pre(1'b1, 3'h2), 10'h000, 0, 1'b1);
		wait_close(10, 1'b0);
		`CHK(at, -1)
		u_sdbpc_host_model.send(pre(1'b1, 3'h2), 10'h000, 0);
		wait_close(12, 1'b1);
		`CHK(v, 8'h49)
		u_sdbpc_host_model.send(pre(1'b0, 3'h1), 10'h000, 0);
		wait_close(12, 1'b0);
		`CHK(at, -1)
		$display("test all done");
	endtask
	task automatic t_read;
		for (int c = 0; c < 3; c++) begin
			cfg(c, 5'h05 - 5'(c * 2));
			h = 2 << c;
			d = (h > h + 3 - c * 2) ? h : h + 3 - c * 2;
			u_sdbpc_host_model.send(act(3'h6), 0, 6);
			u_sdbpc_host_model.send(rw(3'h6, 1'b0), 10'h001, 0);
			wait_close(40, 1'b1);
			`CHK(at, 4 + d)
			`CHK(v, 8'h40)
		end
		u_sdbpc_host_model.send(act(3'h6), 0, 6);
		u_sdbpc_host_model.send(rw(3'h6, 1'b0), 10'h3FE, 0);
		wait_close(40, 1'b0);
		`CHK(at, -1)
		`CHK(BANK_OPEN[6], 1'b1)
		u_sdbpc_host_model.send(pre(1'b0, 3'h6), 10'h000, 8);
		$display("test read done");
	endtask
	task automatic t_write;
		for (int c = 0; c < 3; c++) begin
			cfg(c, 5'h01);
			h = 2 << c;
			u_sdbpc_host_model.send(act(3'h4), 0, 6);
			u_sdbpc_host_model.send(rw(3'h4, 1'b1), 10'h001, 0);
			nw = 0;
			at = -1;
			for (int i = 2; i <= 40; i++) begin
				@(posedge CLK);
				#1;
				if (BANK_CLOSE_START[4] === 1'b1) at = i;
				if (ARRAY_WRITE === 1'b1) begin
					nw++;
					`CHK(ARRAY_WRITE_BANK, 3'h4)
				end
			end
			`CHK(nw, h / 2)
			`CHK(at, 4 + 3 + h + 2)
		end
		$display("test write done");
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (2) @(posedge CLK);
		RESET <= 1'b0;
		t_single;
		t_all;
		t_read;
		t_write;
		tally_and_finish;
	end
endmodule
`default_nettype wire
